// *** verilog/shared_pin_function_mux.sv ***
// Function multiplexer for the phase A, phase B, index and home pads of port C
`timescale 1ns/10ps
`include "pin_mux_map.svh"

module shared_pin_function_mux #(
  parameter bit          FULL_FEATURED = 1'b1,
  parameter int unsigned PIN_COUNT     = 4
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // Pads: phase A companion, phase B, index, home
  input  wire logic [PIN_COUNT-1:0]   pad_in,
  output logic      [PIN_COUNT-1:0]   pad_out,
  output logic      [PIN_COUNT-1:0]   pad_oe,
  output logic      [PIN_COUNT-1:0]   pad_pullup_en,
  // System pin-select bits, taken on cfg_load
  input  wire logic                   cfg_load,
  input  wire logic                   phase_a_alternate_select,
  input  wire logic                   phase_b_alternate_select,
  input  wire logic                   index_alternate_select,
  input  wire logic                   home_alternate_select,
  // Port C configuration
  input  wire logic [PIN_COUNT-1:0]   port_c_gpio_select,
  input  wire logic [PIN_COUNT-1:0]   port_c_pullup_enable,
  input  wire logic [PIN_COUNT-1:0]   port_c_data_out,
  input  wire logic [PIN_COUNT-1:0]   port_c_dir_out,
  output logic      [PIN_COUNT-1:0]   port_c_data_in,
  // Quadrature decoder 1
  output logic                        quad1_phase_a_input,
  output logic                        quad1_phase_b_input,
  output logic                        quad1_index_input,
  output logic                        quad1_home_input,
  // Timer B channels zero to three
  input  wire logic [PIN_COUNT-1:0]   timer_b_channel_out,
  input  wire logic [PIN_COUNT-1:0]   timer_b_channel_oe,
  output logic      [PIN_COUNT-1:0]   timer_b_channel_in,
  // Second SPI core
  input  wire logic                   spi_master_mode,
  input  wire logic                   spi_second_serial_clock_tx,
  input  wire logic                   spi_second_master_out_tx,
  input  wire logic                   spi_second_master_in_tx,
  output logic                        spi_second_serial_clock_rx,
  output logic                        spi_second_master_out_rx,
  output logic                        spi_second_master_in_rx,
  output logic                        spi_second_slave_select_n,
  output logic                        spi_slave_selected,
  // Status
  output logic      [PIN_COUNT-1:0]   pin_is_spi,
  output logic      [PIN_COUNT-1:0]   pin_is_gpio,
  output logic                        config_ready
);
  import pin_mux_pkg::*;

  if (PIN_COUNT != 4) begin : g_bad_count
    $error("shared_pin_function_mux serves exactly four pads");
  end

  // Reduced variant leaves reset with no usable function on any pad
  localparam pin_func_e FUNC_RESET = FULL_FEATURED ? FUNC_QUAD_TIMER : FUNC_NONE;

  pin_func_e            func_reg [PIN_COUNT];
  pin_func_e            func_next [PIN_COUNT];
  logic                 ready_reg, ready_next;
  logic [PIN_COUNT-1:0] alt_sel;

  logic [PIN_COUNT-1:0] spi_out;
  logic [PIN_COUNT-1:0] spi_oe;
  logic [PIN_COUNT-1:0] gpio_oe;
  logic [PIN_COUNT-1:0] periph_in;
  logic [PIN_COUNT-1:0] spi_in;
  logic [PIN_COUNT-1:0] gpio_in;
  logic [PIN_COUNT-1:0] pullup_cfg;

  assign alt_sel[`PM_PIN_PHASE_A] = phase_a_alternate_select;
  assign alt_sel[`PM_PIN_PHASE_B] = phase_b_alternate_select;
  assign alt_sel[`PM_PIN_INDEX]   = index_alternate_select;
  assign alt_sel[`PM_PIN_HOME]    = home_alternate_select;

  // Function selection. Held until the next load so that the reduced
  // variant stays unrouted until software has written a configuration.
  always_comb begin
    ready_next = ready_reg;
    for (int i = 0; i < PIN_COUNT; i++) begin
      func_next[i] = func_reg[i];
      if (cfg_load) begin
        if (port_c_gpio_select[i]) begin
          func_next[i] = FUNC_GPIO;
        end else if (alt_sel[i]) begin
          func_next[i] = FUNC_SPI;
        end else begin
          func_next[i] = FUNC_QUAD_TIMER;
        end
      end
    end
    if (cfg_load) begin
      ready_next = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        func_reg[i] <= FUNC_RESET;
      end
      ready_reg <= FULL_FEATURED;
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        func_reg[i] <= func_next[i];
      end
      ready_reg <= ready_next;
    end
  end

  // Slave select is active low; it only counts when the home pad is routed to SPI
  assign spi_slave_selected = (func_reg[`PM_PIN_HOME] == FUNC_SPI)
                              && !spi_in[`PM_PIN_HOME];

  // SPI drivers. Clock and data pass through the same single register stage,
  // so the half-cycle lead of data over the sampling edge is kept as the core sets it.
  always_comb begin
    spi_out = '0;
    spi_oe  = '0;
    // Clock drives out as master, is an input as slave
    spi_out[`PM_PIN_PHASE_A] = spi_second_serial_clock_tx;
    spi_oe[`PM_PIN_PHASE_A]  = spi_master_mode;
    spi_out[`PM_PIN_PHASE_B] = spi_second_master_out_tx;
    spi_oe[`PM_PIN_PHASE_B]  = spi_master_mode;
    // Slave drives master-in only while selected, else the pad floats
    spi_out[`PM_PIN_INDEX]   = spi_second_master_in_tx;
    spi_oe[`PM_PIN_INDEX]    = !spi_master_mode && spi_slave_selected;
    // Slave select is never driven: input in both modes
    spi_out[`PM_PIN_HOME]    = 1'b0;
    spi_oe[`PM_PIN_HOME]     = 1'b0;
  end

  // Pull-up enables, one bit per pad
  assign pullup_cfg[`PM_PIN_PHASE_A] = port_c_pullup_enable[`PM_PU_BIT_PHASE_A];
  assign pullup_cfg[`PM_PIN_PHASE_B] = port_c_pullup_enable[`PM_PU_BIT_PHASE_B];
  assign pullup_cfg[`PM_PIN_INDEX]   = port_c_pullup_enable[`PM_PU_BIT_INDEX];
  assign pullup_cfg[`PM_PIN_HOME]    = port_c_pullup_enable[`PM_PU_BIT_HOME];

  // Port bit direction: a set direction bit makes the pad an output
  assign gpio_oe = port_c_dir_out;

  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    pin_route_cell u_cell (
      .mclk          (mclk),
      .rst           (rst),
      .func          (func_reg[g]),
      .pullup_cfg    (pullup_cfg[g]),
      .periph_out    (timer_b_channel_out[g]),
      .periph_oe     (timer_b_channel_oe[g]),
      .spi_out       (spi_out[g]),
      .spi_oe        (spi_oe[g]),
      .gpio_out      (port_c_data_out[g]),
      .gpio_oe       (gpio_oe[g]),
      .pad_in        (pad_in[g]),
      .pad_out       (pad_out[g]),
      .pad_oe        (pad_oe[g]),
      .pad_pullup_en (pad_pullup_en[g]),
      .periph_in     (periph_in[g]),
      .spi_in        (spi_in[g]),
      .gpio_in       (gpio_in[g])
    );
  end

  // Decoder inputs; idle high when the pad serves another function
  assign quad1_phase_a_input = periph_in[`PM_PIN_PHASE_A];
  assign quad1_phase_b_input = periph_in[`PM_PIN_PHASE_B];
  assign quad1_index_input   = periph_in[`PM_PIN_INDEX];
  assign quad1_home_input    = periph_in[`PM_PIN_HOME];
  assign timer_b_channel_in  = periph_in;

  // SPI receive side
  assign spi_second_serial_clock_rx = spi_in[`PM_PIN_PHASE_A];
  assign spi_second_master_out_rx   = spi_in[`PM_PIN_PHASE_B];
  assign spi_second_master_in_rx    = spi_in[`PM_PIN_INDEX];
  // Master mode: core watches this for a competing master
  assign spi_second_slave_select_n  = spi_in[`PM_PIN_HOME];

  assign port_c_data_in = gpio_in;

  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      pin_is_spi[i]  = (func_reg[i] == FUNC_SPI);
      pin_is_gpio[i] = (func_reg[i] == FUNC_GPIO);
    end
  end

  assign config_ready = ready_reg;

endmodule

// *** verilog/pin_mux_map.svh ***
// Pin indices, pull-up bit positions and reset values of the shared pin multiplexer
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH

// Pad index of each multiplexed pin
`define PM_PIN_PHASE_A      2'h0
`define PM_PIN_PHASE_B      2'h1
`define PM_PIN_INDEX        2'h2
`define PM_PIN_HOME         2'h3

// Bit of port_c_pullup_enable that controls each pad's pull-up
`define PM_PU_BIT_PHASE_A   0
`define PM_PU_BIT_PHASE_B   1
`define PM_PU_BIT_INDEX     2
`define PM_PU_BIT_HOME      3

// Reset values
`define PM_PULLUP_RESET     4'hF
`define PM_GPIO_SEL_RESET   4'h0
`define PM_IN_IDLE          1'h1

`endif

// *** verilog/pin_mux_pkg.sv ***
// Types shared by the shared pin multiplexer modules
package pin_mux_pkg;

  // Function routed onto a pad
  typedef enum logic [1:0] {
    FUNC_QUAD_TIMER,
    FUNC_SPI,
    FUNC_GPIO,
    FUNC_NONE
  } pin_func_e;

endpackage

// *** verilog/pin_route_cell.sv ***
// One multiplexed pad: selects the driver of the pad and routes its input to the selected function and to the port bit
`timescale 1ns/10ps
`include "pin_mux_map.svh"

module pin_route_cell (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // Selection
  input  wire pin_mux_pkg::pin_func_e func,
  input  wire logic                  pullup_cfg,
  // Function drivers
  input  wire logic                  periph_out,
  input  wire logic                  periph_oe,
  input  wire logic                  spi_out,
  input  wire logic                  spi_oe,
  input  wire logic                  gpio_out,
  input  wire logic                  gpio_oe,
  // Pad
  input  wire logic                  pad_in,
  output logic                       pad_out,
  output logic                       pad_oe,
  output logic                       pad_pullup_en,
  // Routed inputs
  output logic                       periph_in,
  output logic                       spi_in,
  output logic                       gpio_in
);
  import pin_mux_pkg::*;

  logic pad_out_reg, pad_out_next;
  logic pad_oe_reg, pad_oe_next;
  logic pullup_reg, pullup_next;
  logic periph_in_reg, periph_in_next;
  logic spi_in_reg, spi_in_next;
  logic gpio_in_reg, gpio_in_next;

  always_comb begin
    pad_out_next   = 1'b0;
    pad_oe_next    = 1'b0;
    periph_in_next = `PM_IN_IDLE;
    spi_in_next    = `PM_IN_IDLE;
    pullup_next    = pullup_cfg;
    // Port bit always sees the pad, as a GPIO data read would
    gpio_in_next   = pad_in;
    // Only the selected function may drive the pad; of the others only the port bit still sees it
    unique case (func)
      FUNC_QUAD_TIMER: begin
        pad_out_next   = periph_out;
        pad_oe_next    = periph_oe;
        periph_in_next = pad_in;
      end
      FUNC_SPI: begin
        pad_out_next = spi_out;
        pad_oe_next  = spi_oe;
        spi_in_next  = pad_in;
      end
      FUNC_GPIO: begin
        pad_out_next = gpio_out;
        pad_oe_next  = gpio_oe;
      end
      FUNC_NONE: begin
        pad_oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      // Input with pull-up while reset holds
      pad_out_reg   <= 1'b0;
      pad_oe_reg    <= 1'b0;
      pullup_reg    <= 1'b1;
      periph_in_reg <= `PM_IN_IDLE;
      spi_in_reg    <= `PM_IN_IDLE;
      gpio_in_reg   <= `PM_IN_IDLE;
    end else begin
      pad_out_reg   <= pad_out_next;
      pad_oe_reg    <= pad_oe_next;
      pullup_reg    <= pullup_next;
      periph_in_reg <= periph_in_next;
      spi_in_reg    <= spi_in_next;
      gpio_in_reg   <= gpio_in_next;
    end
  end

  assign pad_out       = pad_out_reg;
  assign pad_oe        = pad_oe_reg;
  assign pad_pullup_en = pullup_reg;
  assign periph_in     = periph_in_reg;
  assign spi_in        = spi_in_reg;
  assign gpio_in       = gpio_in_reg;

endmodule

// *** testbench/pin_mux_props.sv ***
// Concurrent checks on the ports of the shared pin function multiplexer
`timescale 1ns/10ps
module pin_mux_props #(
  parameter int unsigned PIN_COUNT = 4
) (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic [PIN_COUNT-1:0] pad_in,
  input wire logic [PIN_COUNT-1:0] pad_out,
  input wire logic [PIN_COUNT-1:0] pad_oe,
  input wire logic [PIN_COUNT-1:0] pad_pullup_en,
  input wire logic [PIN_COUNT-1:0] port_c_pullup_enable,
  input wire logic [PIN_COUNT-1:0] port_c_dir_out,
  input wire logic [PIN_COUNT-1:0] pin_is_spi,
  input wire logic [PIN_COUNT-1:0] pin_is_gpio,
  input wire logic                 quad1_phase_b_input,
  input wire logic                 quad1_index_input,
  input wire logic                 quad1_home_input,
  input wire logic                 spi_master_mode,
  input wire logic                 spi_second_master_out_tx,
  input wire logic                 spi_second_slave_select_n,
  input wire logic                 spi_slave_selected
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  reset_state_a: assert property (
    $fell(rst) |-> pad_oe == 4'h0 && pad_pullup_en == 4'hF) else $error("pad not idle in reset");
  reset_route_a: assert property (
    $fell(rst) |-> pin_is_spi == 4'h0 && pin_is_gpio == 4'h0) else $error("bad reset routing");
  pullup_follow_a: assert property (
    !rst |=> pad_pullup_en == $past(port_c_pullup_enable)) else $error("pull-up mismatch");
  quad_route_a: assert property (
    pin_is_spi == 4'h0 && pin_is_gpio == 4'h0 |=> {quad1_home_input, quad1_index_input,
    quad1_phase_b_input} == $past(pad_in[3:1])) else $error("decoder input not routed");
  mosi_drive_a: assert property (
    pin_is_spi[1] && spi_master_mode |=> pad_oe[1] && pad_out[1] == $past(spi_second_master_out_tx))
    else $error("master-out not driven");
  miso_hiz_a: assert property (
    pin_is_spi[2] && !spi_master_mode && !spi_slave_selected |=> !pad_oe[2])
    else $error("unselected slave drives master-in");
  slave_select_a: assert property (
    pin_is_spi[3] |=> !pad_oe[3] && spi_second_slave_select_n == $past(pad_in[3]))
    else $error("slave select not an input");
  gpio_dir_a: assert property (
    pin_is_gpio[1] |=> pad_oe[1] == $past(port_c_dir_out[1])) else $error("port direction wrong");
endmodule

bind shared_pin_function_mux pin_mux_props #(.PIN_COUNT(PIN_COUNT)) props_i (
  .mclk, .rst, .pad_in, .pad_out, .pad_oe, .pad_pullup_en, .port_c_pullup_enable,
  .port_c_dir_out, .pin_is_spi, .pin_is_gpio, .quad1_phase_b_input, .quad1_index_input,
  .quad1_home_input, .spi_master_mode, .spi_second_master_out_tx, .spi_second_slave_select_n,
  .spi_slave_selected);

// *** testbench/far_side_pins.sv ***
// Model of the encoder, SPI peer and wiring beyond the shared pads
`timescale 1ns/10ps
module far_side_pins (
  input  wire logic       mclk,
  input  wire logic [3:0] pad_out,
  input  wire logic [3:0] pad_oe,
  input  wire logic [3:0] pad_pullup_en,
  input  wire logic [3:0] ext_drive,
  input  wire logic [3:0] ext_oe,
  output logic      [3:0] pad_in
);
  logic [3:0] float_reg = 4'h5;
  // A floating pad without pull-up wanders, so no one may lean on its old level
  always_ff @(posedge mclk) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (pad_oe[k]) begin
        pad_in[k] = pad_out[k];
      end else if (ext_oe[k]) begin
        pad_in[k] = ext_drive[k];
      end else begin
        pad_in[k] = pad_pullup_en[k] ? 1'b1 : float_reg[k];
      end
    end
  end
endmodule

// *** testbench/test_shared_pin_function_mux.sv ***
// Self-checking bench for the shared pin function multiplexer
`timescale 1ns/10ps
module test_shared_pin_function_mux;
  logic       mclk, rst, cfg_load, alt_a, alt_b, alt_i, alt_h, master, sclk_tx, mosi_tx, miso_tx;
  logic [3:0] gsel, pue, dout, dir, ext_drive, ext_oe, pad_in, pad_out, pad_oe, pad_pullup_en;
  logic [3:0] data_in, is_spi, is_gpio, tmr_in, tmr_out, tmr_oe;
  logic       ph_a, ph_b, idx, home, miso_rx, ss_n, selected, sclk_rx, mosi_rx, ready;
  int         fails, num_checks;

  shared_pin_function_mux #(.FULL_FEATURED(1'b1), .PIN_COUNT(4)) DUT (
    .mclk, .rst, .pad_in, .pad_out, .pad_oe, .pad_pullup_en, .cfg_load,
    .phase_a_alternate_select(alt_a), .phase_b_alternate_select(alt_b),
    .index_alternate_select(alt_i), .home_alternate_select(alt_h), .port_c_gpio_select(gsel),
    .port_c_pullup_enable(pue), .port_c_data_out(dout), .port_c_dir_out(dir),
    .port_c_data_in(data_in), .quad1_phase_a_input(ph_a), .quad1_phase_b_input(ph_b),
    .quad1_index_input(idx), .quad1_home_input(home), .timer_b_channel_out(tmr_out),
    .timer_b_channel_oe(tmr_oe), .timer_b_channel_in(tmr_in), .spi_master_mode(master),
    .spi_second_serial_clock_tx(sclk_tx), .spi_second_master_out_tx(mosi_tx),
    .spi_second_master_in_tx(miso_tx), .spi_second_serial_clock_rx(sclk_rx),
    .spi_second_master_out_rx(mosi_rx), .spi_second_master_in_rx(miso_rx),
    .spi_second_slave_select_n(ss_n), .spi_slave_selected(selected), .pin_is_spi(is_spi),
    .pin_is_gpio(is_gpio), .config_ready(ready));
  far_side_pins FAR (.mclk, .pad_out, .pad_oe, .pad_pullup_en, .ext_drive, .ext_oe, .pad_in);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic load_cfg(input logic [3:0] alts, input logic [3:0] g);
    @(posedge mclk);
    cfg_load <= 1'b1;
    {alt_a, alt_b, alt_i, alt_h} <= alts;
    gsel <= g;
    @(posedge mclk);
    cfg_load <= 1'b0;
    settle(3);
  endtask

  task automatic end_of_test;
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Pull-up bits are all clear in reset, yet every pad must stay a pulled-up input
  task automatic t_reset;
    settle(19);
    check(pad_oe, 4'h0, "reset drive");
    check(pad_pullup_en, 4'hF, "reset pull-up");
    check(is_spi | is_gpio, 4'h0, "reset routing");
    check({3'b000, ready}, 4'h1, "ready after reset");
    @(posedge mclk);
    rst <= 1'b0;
    pue <= 4'hF;
  endtask

  task automatic t_quad;
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      ext_oe <= 4'hF;
      ext_drive <= k ? 4'hB : 4'h4;
      settle(2);
      check({home, idx, ph_b, ph_a}, k ? 4'hB : 4'h4, "decoder");
      check(tmr_in, k ? 4'hB : 4'h4, "timer in");
    end
  endtask

  task automatic t_pullup;
    for (int k = 1; k < 4; k++) begin
      @(posedge mclk);
      pue <= 4'hF ^ (4'h1 << k);
      settle(2);
      check(pad_pullup_en, 4'hF ^ (4'h1 << k), "pull-up");
    end
    @(posedge mclk);
    pue <= 4'hF;
  endtask

  task automatic t_spi_master;
    ext_oe <= 4'h4;
    ext_drive <= 4'h0;
    master <= 1'b1;
    sclk_tx <= 1'b1;
    load_cfg(4'hF, 4'h0);
    check(pad_oe, 4'h3, "master drive");
    check({2'b00, pad_out[1:0]}, 4'h1, "master out");
    check({3'b000, ph_b}, 4'h1, "unselected decoder");
    check({3'b000, miso_rx}, 4'h0, "master in low");
    @(posedge mclk);
    mosi_tx <= 1'b1;
    ext_drive <= 4'h4;
    settle(2);
    check({3'b000, pad_out[1]}, 4'h1, "master out high");
    check({3'b000, miso_rx}, 4'h1, "master in high");
  endtask

  task automatic t_spi_slave;
    @(posedge mclk);
    master <= 1'b0;
    ext_oe <= 4'hB;
    ext_drive <= 4'h8;
    settle(3);
    check(pad_oe, 4'h0, "idle slave");
    check({2'b00, sclk_rx, mosi_rx}, 4'h0, "slave clock data low");
    @(posedge mclk);
    ext_drive <= 4'h3;
    miso_tx <= 1'b1;
    settle(3);
    check({2'b00, ss_n, selected}, 4'h1, "select");
    check({2'b00, sclk_rx, mosi_rx}, 4'h3, "slave clock data high");
    check(pad_oe, 4'h4, "slave drive");
    check({3'b000, pad_out[2]}, 4'h1, "slave out");
  endtask

  // Timer drives every pad, but only the pad left on its function may obey it
  task automatic t_gpio;
    @(posedge mclk);
    tmr_oe <= 4'hF;
    tmr_out <= 4'hF;
    dir <= 4'h2;
    dout <= 4'h2;
    ext_oe <= 4'hC;
    ext_drive <= 4'h4;
    load_cfg(4'h0, 4'hE);
    check(pad_oe, 4'h3, "port drive");
    check({3'b000, pad_out[0]}, 4'h1, "timer drive");
    check({pad_out[1], 1'b0, data_in[3:2]}, 4'h9, "port data");
    check({3'b000, idx}, 4'h1, "decoder off");
    @(posedge mclk);
    dir <= 4'h4;
    ext_oe <= 4'h8;
    settle(2);
    check(pad_oe, 4'h5, "port turn");
  endtask

  initial begin
    {rst, cfg_load, alt_a, alt_b, alt_i, alt_h} = 6'h20;
    {master, sclk_tx, mosi_tx, miso_tx} = 4'h0;
    {tmr_out, tmr_oe} = 8'h00;
    {gsel, pue, dout, dir, ext_drive, ext_oe} = 24'h0;
    fails = 0;
    num_checks = 0;
    t_reset();
    t_quad();
    t_pullup();
    t_spi_master();
    t_spi_slave();
    t_gpio();
    end_of_test();
  end

  // All scenarios take about 60 cycles, so 5000 leaves ample margin
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    end_of_test();
  end
endmodule
